//--- hw/ccs_defines.svh
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CCS_ADDR_W 12
`define CCS_CTRL_OFS 12'h000
`define CCS_STAT_OFS 12'h004

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CCS_CTRL_W 4
`define CCS_CTRL_RST 4'h0
`define CCS_SEL_SECOND_BIT 0
`define CCS_SEL_FIRST_BIT 1
`define CCS_A_DIS_BIT 2
`define CCS_B_DIS_BIT 3

// ----------------------------------------
// status register fields
// ----------------------------------------
`define CCS_STAT_A_ACT_BIT 0
`define CCS_STAT_B_ACT_BIT 1
`define CCS_STAT_ROUTE_LSB 2

// ----------------------------------------
// fanout
// ----------------------------------------
`define CCS_BANK_PAIRS 3
`define CCS_BANKS 2
`define CCS_SYNC_STAGES 2

`endif

//--- hw/ccs_pkg.sv
package ccs_pkg;

  // route mode: bit1 is the first select, bit0 the second
  typedef enum logic [1:0] {
    CCS_ZERO_ALL = 2'b00,
    CCS_ONE_ALL = 2'b01,
    CCS_SPLIT = 2'b10,
    CCS_CROSS = 2'b11
  } ccs_route_t;

  typedef struct packed {
    logic b_dis;
    logic a_dis;
    ccs_route_t route;
  } ccs_ctrl_t;

  typedef struct packed {
    logic [2:0] true_lvl;
    logic [2:0] comp_lvl;
  } ccs_bank_out_t;

endpackage

//--- hw/ccs_bank_gate.sv
`timescale 1ns/1ns
`include "ccs_defines.svh"

module ccs_bank_gate #(
  parameter int WIDTH = `CCS_BANK_PAIRS
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ref_lvl_in,
  input wire logic disable_in,
  output logic active_out,
  output logic [WIDTH-1:0] true_out,
  output logic [WIDTH-1:0] comp_out
);

  logic active_q;
  logic [WIDTH-1:0] true_q;
  logic [WIDTH-1:0] comp_q;

  // ----------------------------------------
  // gate state, moves only in low phase
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      active_q <= 1'b0;
    end else if (!ref_lvl_in) begin
      active_q <= !disable_in;
    end
  end

  // ----------------------------------------
  // output pairs
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      true_q <= '0;
      comp_q <= '1;
    end else begin
      true_q <= {WIDTH{ref_lvl_in & active_q}};
      comp_q <= {WIDTH{~(ref_lvl_in & active_q)}};
    end
  end

  assign active_out = active_q;
  assign true_out = true_q;
  assign comp_out = comp_q;

endmodule

//--- hw/ccs_switch.sv
`timescale 1ns/1ns
`include "ccs_defines.svh"


module ccs_switch #(
  parameter int PAIRS = `CCS_BANK_PAIRS
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`CCS_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic ref_input_zero_in,
  input wire logic ref_input_one_in,
  output logic [PAIRS-1:0] bank_a_outputs_out,
  output logic [PAIRS-1:0] bank_a_outputs_n_out,
  output logic [PAIRS-1:0] bank_b_outputs_out,
  output logic [PAIRS-1:0] bank_b_outputs_n_out
);

  // ----------------------------------------
  // routing decode
  // ----------------------------------------
  function automatic logic route_lvl(input ccs_pkg::ccs_route_t route, input logic bank_b,
                                     input logic zero_lvl, input logic one_lvl);
    logic lvl;
    lvl = zero_lvl;
    unique case (route)
      ccs_pkg::CCS_ZERO_ALL: lvl = zero_lvl;
      ccs_pkg::CCS_ONE_ALL: lvl = one_lvl;
      ccs_pkg::CCS_SPLIT: lvl = bank_b ? one_lvl : zero_lvl;
      ccs_pkg::CCS_CROSS: lvl = bank_b ? zero_lvl : one_lvl;
    endcase
    return lvl;
  endfunction

  ccs_pkg::ccs_ctrl_t ctrl_q;
  logic [`CCS_SYNC_STAGES-1:0] zero_sync_q;
  logic [`CCS_SYNC_STAGES-1:0] one_sync_q;
  logic zero_lvl;
  logic one_lvl;
  logic [`CCS_BANKS-1:0] src_lvl;
  logic [`CCS_BANKS-1:0] bank_dis;
  logic [`CCS_BANKS-1:0] bank_act;
  ccs_pkg::ccs_bank_out_t [`CCS_BANKS-1:0] bank_out;
  logic setup_phase;
  logic access_wr;
  logic ctrl_hit;
  logic stat_hit;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rd_mux;
  logic rd_err;

  // ----------------------------------------
  // reference input synchronisers
  // ----------------------------------------
  // both references sampled
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      zero_sync_q <= '0;
      one_sync_q <= '0;
    end else begin
      zero_sync_q <= {zero_sync_q[0], ref_input_zero_in};
      one_sync_q <= {one_sync_q[0], ref_input_one_in};
    end
  end

  assign zero_lvl = zero_sync_q[1];
  assign one_lvl = one_sync_q[1];

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign setup_phase = psel_in & !penable_in;
  assign access_wr = psel_in & penable_in & pwrite_in;
  assign ctrl_hit = (paddr_in == `CCS_CTRL_OFS);
  assign stat_hit = (paddr_in == `CCS_STAT_OFS);
  assign pready_out = psel_in & penable_in;
  assign prdata_out = prdata_q;
  assign pslverr_out = pslverr_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (ctrl_hit) begin
      rd_mux[`CCS_CTRL_W-1:0] = ctrl_q;
    end else if (stat_hit) begin
      rd_mux[`CCS_STAT_A_ACT_BIT] = bank_act[0];
      rd_mux[`CCS_STAT_B_ACT_BIT] = bank_act[1];
      rd_mux[`CCS_STAT_ROUTE_LSB +: 2] = ctrl_q.route;
      rd_err = pwrite_in;
    end else begin
      rd_err = 1'b1;
    end
  end

  // read data and error captured in setup, shown in access
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= pwrite_in ? 32'h0000_0000 : rd_mux;
      pslverr_q <= rd_err;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // select defaults to 00
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_q <= `CCS_CTRL_RST;
    end else if (access_wr && ctrl_hit && pstrb_in[0]) begin
      ctrl_q <= pwdata_in[`CCS_CTRL_W-1:0];
    end
  end

  // ----------------------------------------
  // per-bank routing and gating
  // ----------------------------------------
  assign bank_dis[0] = ctrl_q.a_dis;
  assign bank_dis[1] = ctrl_q.b_dis;

  generate
    for (genvar b = 0; b < `CCS_BANKS; b++) begin : g_bank
      assign src_lvl[b] = route_lvl(ctrl_q.route, (b == 1), zero_lvl, one_lvl);

      ccs_bank_gate #(
        .WIDTH(PAIRS)
      ) u_gate (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ref_lvl_in(src_lvl[b]),
        .disable_in(bank_dis[b]),
        .active_out(bank_act[b]),
        .true_out(bank_out[b].true_lvl),
        .comp_out(bank_out[b].comp_lvl)
      );
    end
  endgenerate

  assign bank_a_outputs_out = bank_out[0].true_lvl;
  assign bank_a_outputs_n_out = bank_out[0].comp_lvl;
  assign bank_b_outputs_out = bank_out[1].true_lvl;
  assign bank_b_outputs_n_out = bank_out[1].comp_lvl;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_route_held(ccs_pkg::ccs_route_t m);
    ctrl_q.route == m [*2];
  endsequence

  property p_ref_sampled;
    1'b1 |-> ##2 (zero_lvl == $past(ref_input_zero_in, 2)) && (one_lvl == $past(ref_input_one_in, 2));
  endproperty
  a_ref_sampled: assert property (p_ref_sampled) else $error("reference sample path wrong");

  property p_pairs_inverse;
    (bank_a_outputs_n_out == ~bank_a_outputs_out) && (bank_b_outputs_n_out == ~bank_b_outputs_out);
  endproperty
  a_pairs_inverse: assert property (p_pairs_inverse) else $error("complement not inverse");

  property p_zero_all;
    s_route_held(ccs_pkg::CCS_ZERO_ALL) ##0 ($past(bank_act) == 2'b11)
      |-> (bank_a_outputs_out[0] == $past(zero_lvl)) && (bank_b_outputs_out[0] == $past(zero_lvl));
  endproperty
  a_zero_all: assert property (p_zero_all) else $error("zero not on all outputs");

  property p_one_all;
    s_route_held(ccs_pkg::CCS_ONE_ALL) ##0 ($past(bank_act) == 2'b11)
      |-> (bank_a_outputs_out[0] == $past(one_lvl)) && (bank_b_outputs_out[0] == $past(one_lvl));
  endproperty
  a_one_all: assert property (p_one_all) else $error("one not on all outputs");

  property p_split;
    s_route_held(ccs_pkg::CCS_SPLIT) ##0 ($past(bank_act) == 2'b11)
      |-> (bank_a_outputs_out[1] == $past(zero_lvl)) && (bank_b_outputs_out[1] == $past(one_lvl));
  endproperty
  a_split: assert property (p_split) else $error("split routing wrong");

  property p_cross;
    s_route_held(ccs_pkg::CCS_CROSS) ##0 ($past(bank_act) == 2'b11)
      |-> (bank_a_outputs_out[2] == $past(one_lvl)) && (bank_b_outputs_out[2] == $past(zero_lvl));
  endproperty
  a_cross: assert property (p_cross) else $error("crossed routing wrong");

  property p_default_route;
    $fell(srst_in) |-> (ctrl_q.route == ccs_pkg::CCS_ZERO_ALL) && !ctrl_q.a_dis && !ctrl_q.b_dis;
  endproperty
  a_default_route: assert property (@(posedge clk_in) p_default_route) else $error("control not at default");

  property p_enabled_stays;
    (bank_act[0] && !bank_dis[0]) |=> bank_act[0];
  endproperty
  a_enabled_stays: assert property (p_enabled_stays) else $error("enabled bank dropped");

  property p_disabled_levels;
    (!bank_act[0] && !bank_act[1]) |=> (bank_a_outputs_out == '0) && (bank_b_outputs_n_out == '1);
  endproperty
  a_disabled_levels: assert property (p_disabled_levels) else $error("disabled levels wrong");

  property p_disable_taken;
    (bank_dis[1] && !src_lvl[1]) |=> !bank_act[1];
  endproperty
  a_disable_taken: assert property (p_disable_taken) else $error("disable not taken in low phase");

  sequence s_clean_rise;
    !$past(src_lvl[0], 2) && $past(src_lvl[0]);
  endsequence

  property p_whole_periods;
    $rose(bank_a_outputs_out[0]) |-> s_clean_rise;
  endproperty
  a_whole_periods: assert property (p_whole_periods) else $error("output rose off a clock edge");

  property p_own_bank;
    $changed(bank_act[0]) |-> (bank_act[0] == !$past(bank_dis[0]));
  endproperty
  a_own_bank: assert property (p_own_bank) else $error("bank A gate followed wrong control");

  property p_low_phase_only;
    $changed(bank_act[1]) |-> !$past(src_lvl[1]);
  endproperty
  a_low_phase_only: assert property (p_low_phase_only) else $error("gate moved in high phase");

endmodule

//--- test/ccs_ref_src.sv
`timescale 1ns/1ns

// ----------------------------------------
// reference clock sources
// ----------------------------------------
module ccs_ref_src #(
  parameter int HALF0 = 4,
  parameter int HALF1 = 6
) (
  input wire logic clk_in,
  output logic ref_zero_out,
  output logic ref_one_out
);
  int cnt0 = 0;
  int cnt1 = 0;

  initial begin
    ref_zero_out = 1'b0;
    ref_one_out = 1'b0;
  end

  always @(posedge clk_in) begin
    cnt0 <= (cnt0 == HALF0 - 1) ? 0 : cnt0 + 1;
    cnt1 <= (cnt1 == HALF1 - 1) ? 0 : cnt1 + 1;
    if (cnt0 == HALF0 - 1) begin
      ref_zero_out <= ~ref_zero_out;
    end
    if (cnt1 == HALF1 - 1) begin
      ref_one_out <= ~ref_one_out;
    end
  end
endmodule

//--- test/ccs_switch_bench.sv
`timescale 1ns/1ns
`include "ccs_defines.svh"

module ccs_switch_bench;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000;
  logic [3:0] pstrb_in = 4'hF;
  logic pready_out, pslverr_out, ref0, ref1, er;
  logic [31:0] prdata_out, rd;
  logic [2:0] qa, qa_n, qb, qb_n;
  logic [2:0] h0 = 3'h0;
  logic [2:0] h1 = 3'h0;
  logic mon = 1'b0;
  int run_a = 0;
  int run_b = 0;
  int min_a = 99;
  int min_b = 99;
  int error_cnt = 0;
  int samples_checked = 0;

  always #5 clk_in = ~clk_in;

  ccs_ref_src #(.HALF0(4), .HALF1(6)) ref_src (.clk_in(clk_in), .ref_zero_out(ref0), .ref_one_out(ref1));

  ccs_switch uut (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .ref_input_zero_in(ref0), .ref_input_one_in(ref1), .bank_a_outputs_out(qa),
    .bank_a_outputs_n_out(qa_n), .bank_b_outputs_out(qb), .bank_b_outputs_n_out(qb_n));

  // ----------------------------------------
  // reference history and pulse monitor
  // ----------------------------------------
  always @(posedge clk_in) begin
    h0 <= {h0[1:0], ref0};
    h1 <= {h1[1:0], ref1};
    run_a <= qa[0] ? run_a + 1 : 0;
    run_b <= qb[0] ? run_b + 1 : 0;
    if (mon && !qa[0] && run_a != 0 && run_a < min_a) begin
      min_a <= run_a;
    end
    if (mon && !qb[0] && run_b != 0 && run_b < min_b) begin
      min_b <= run_b;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [3:0] strb);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= wd;
    pstrb_in <= strb;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      test_done();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic check_banks(input int n, input logic sa, input logic sb, input logic da, input logic db);
    logic ea, eb;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      ea = da ? 1'b0 : (sa ? h1[2] : h0[2]);
      eb = db ? 1'b0 : (sb ? h1[2] : h0[2]);
      check("banks", {qa, qa_n, qb, qb_n}, {{3{ea}}, {3{~ea}}, {3{eb}}, {3{~eb}}});
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [3:0] m;
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    apb(1'b0, `CCS_CTRL_OFS, 32'h0, 4'hF);
    check("ctrl_reset", rd, 32'h0);
    apb(1'b0, `CCS_STAT_OFS, 32'h0, 4'hF);
    check("stat_reset", rd, 32'h3);
    apb(1'b1, `CCS_STAT_OFS, 32'hF, 4'hF);
    check("stat_write_err", er, 1);
    apb(1'b0, 12'h008, 32'h0, 4'hF);
    check("unmapped_err", er, 1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b1, `CCS_CTRL_OFS, 32'h3, 4'hE);
    apb(1'b0, `CCS_CTRL_OFS, 32'h0, 4'hF);
    check("ctrl_no_lane", rd, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      m = i[3:0];
      apb(1'b1, `CCS_CTRL_OFS, {28'h0, m}, 4'hF);
      repeat (10) @(posedge clk_in);
      check_banks(24, m[0], m[1] ^ m[0], 1'b0, 1'b0);
      apb(1'b0, `CCS_STAT_OFS, 32'h0, 4'hF);
      check("stat_route", rd, {26'h0, m[1:0], 2'h3});
    end
    $display("test routing done");
    for (int d = 1; d < 4; d++) begin
      m = d[3:0];
      apb(1'b1, `CCS_CTRL_OFS, {28'h0, m[1:0], 2'h0}, 4'hF);
      repeat (10) @(posedge clk_in);
      check_banks(24, 1'b0, 1'b0, m[0], m[1]);
      apb(1'b0, `CCS_STAT_OFS, 32'h0, 4'hF);
      check("stat_active", rd, {30'h0, ~m[1], ~m[0]});
    end
    $display("test disable done");
    apb(1'b1, `CCS_CTRL_OFS, 32'h2, 4'hF);
    repeat (10) @(posedge clk_in);
    mon = 1'b1;
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      apb(1'b1, `CCS_CTRL_OFS, {28'h0, m[1:0], 2'h2}, 4'hF);
      repeat (i) @(posedge clk_in);
    end
    apb(1'b1, `CCS_CTRL_OFS, 32'h2, 4'hF);
    repeat (20) @(posedge clk_in);
    mon = 1'b0;
    check("min_high_a", min_a, 4);
    check("min_high_b", min_b, 6);
    check_banks(12, 1'b0, 1'b1, 1'b0, 1'b0);
    $display("test gating done");
    test_done();
  end
endmodule
